// ==== hw/msr_defs.vh ====
// Offsets, field positions, reset values and sizes of the sensor output and status register group.
// Assumes an 8-bit register address space and 8-bit register data.
`ifndef MSR_DEFS_VH
`define MSR_DEFS_VH

`define MSR_ADDR_W            8
`define MSR_DATA_W            8

`define MSR_OFS_MOTION_THR    8'h1f
`define MSR_OFS_INT_FLAGS     8'h3a
`define MSR_OFS_ACCEL_X_HI    8'h3b
`define MSR_OFS_ACCEL_X_LO    8'h3c
`define MSR_OFS_ACCEL_Y_HI    8'h3d
`define MSR_OFS_ACCEL_Y_LO    8'h3e
`define MSR_OFS_ACCEL_Z_HI    8'h3f
`define MSR_OFS_ACCEL_Z_LO    8'h40
`define MSR_OFS_TEMP_HI       8'h41
`define MSR_OFS_TEMP_LO       8'h42
`define MSR_OFS_RATE_X_HI     8'h43
`define MSR_OFS_RATE_X_LO     8'h44
`define MSR_OFS_RATE_Y_HI     8'h45
`define MSR_OFS_RATE_Y_LO     8'h46
`define MSR_OFS_RATE_Z_HI     8'h47
`define MSR_OFS_RATE_Z_LO     8'h48
`define MSR_OFS_PATH_RESET    8'h68
`define MSR_OFS_MOTION_CTRL   8'h69
`define MSR_OFS_USER_CTRL     8'h6a

`define MSR_FLAG_WAKE_HI      7
`define MSR_FLAG_WAKE_LO      5
`define MSR_FLAG_OVERFLOW     4
`define MSR_FLAG_DRIVE_READY  2
`define MSR_FLAG_SAMPLE_READY 0

`define MSR_BIT_ACCEL_RST     1
`define MSR_BIT_TEMP_RST      0
`define MSR_BIT_ALL_RST       0
`define MSR_BIT_DETECT_EN     7
`define MSR_BIT_COMPARE_MODE  6

`define MSR_WAKE_ENABLED      3'h7
`define MSR_RST_MOTION_THR    8'h00
`define MSR_RST_MOTION_CTRL   2'h0
`define MSR_RST_SAMPLE        16'h0000
`define MSR_RST_FLAG          1'b0
`define MSR_READ_NONE         8'h00

`define MSR_SAMPLE_WORDS      7
`define MSR_SAMPLE_W          16
`define MSR_ACCEL_AXES        3

`endif

// ==== hw/msr_sample_bank.v ====
// Holds the seven 16-bit sensor output words: accel X/Y/Z, temperature, rate X/Y/Z.
// Assumes the front end presents one complete sample set per sample_valid_i pulse.
`timescale 1ns/10ps
`include "msr_defs.vh"

module msr_sample_bank #(
    parameter WORDS = `MSR_SAMPLE_WORDS,
    parameter W     = `MSR_SAMPLE_W
) (
    input  wire               clk_i,
    input  wire               srst_i,
    input  wire               capture_i,
    input  wire               clear_i,
    input  wire [WORDS*W-1:0] sample_i,
    output wire [WORDS*W-1:0] words_o
);

    reg [W-1:0] word_q [0:WORDS-1];

    // Every word loads on the same strike, so the bank never holds words from two samples.
    genvar gi;
    generate
        for (gi = 0; gi < WORDS; gi = gi + 1) begin : g_word
            always @(posedge clk_i) begin
                if (srst_i || clear_i) begin
                    word_q[gi] <= `MSR_RST_SAMPLE;
                end else if (capture_i) begin
                    word_q[gi] <= sample_i[gi*W +: W];
                end
            end
            assign words_o[gi*W +: W] = word_q[gi];
        end
    endgenerate

endmodule

// ==== hw/msr_motion_det.v ====
// Wake-on-motion detector: compares each accelerometer sample with the one before it.
// Assumes accel_i is valid in the cycle sample_i is high.
`timescale 1ns/10ps
`include "msr_defs.vh"

module msr_motion_det #(
    parameter AXES      = `MSR_ACCEL_AXES,
    parameter W         = `MSR_SAMPLE_W,
    parameter THR_SHIFT = 0
) (
    input  wire              clk_i,
    input  wire              srst_i,
    input  wire              path_rst_i,
    input  wire              enable_i,
    input  wire              compare_mode_i,
    input  wire [7:0]        threshold_i,
    input  wire              sample_i,
    input  wire [AXES*W-1:0] accel_i,
    output reg               event_o
);

    reg  [AXES*W-1:0] prev_q;
    reg               have_prev_q;
    wire [AXES-1:0]   over;
    wire [W:0]        limit = {{(W-8){1'b0}}, threshold_i, 1'b0} >> (1 + 0) << THR_SHIFT;
    wire              run = enable_i && compare_mode_i;

    genvar gi;
    generate
        for (gi = 0; gi < AXES; gi = gi + 1) begin : g_axis
            wire signed [W:0] diff = $signed({accel_i[gi*W+W-1], accel_i[gi*W +: W]})
                                   - $signed({prev_q[gi*W+W-1], prev_q[gi*W +: W]});
            wire [W:0] mag = diff[W] ? (~diff + 1'b1) : diff;
            assign over[gi] = (mag > limit);
        end
    endgenerate

    always @(posedge clk_i) begin
        if (srst_i || path_rst_i || !run) begin
            prev_q      <= {AXES*W{1'b0}};
            have_prev_q <= 1'b0;
            event_o     <= 1'b0;
        end else begin
            event_o <= 1'b0;
            if (sample_i) begin
                prev_q      <= accel_i;
                have_prev_q <= 1'b1;
                event_o     <= have_prev_q && (|over);
            end
        end
    end

endmodule

// ==== hw/msr_regs.v ====
// Interrupt status, sensor output, path reset and motion control registers of the sensor core.
// Assumes a simple synchronous register port driven by the serial host interface front end.
//
// Function
// - Motion event shows as 111 in flag bits 7:5, cleared by status read.
// - Overflow flag bit 4 sets on queue overflow, cleared by status read.
// - Sample-ready flag bit 0 sets on data-ready, cleared by status read.
// - Drive-ready flag in bit 2; bits 3 and 1 read zero.
// - Accel X/Y/Z high then low bytes at 3b..40, read only.
// - Temperature high byte at 41, low byte at 42, read only.
// - Rate X/Y/Z high then low bytes at 43..48, read only.
// - Rate codes pass through proportional to angular rate, 65.5 codes per dps.
// - Accel path reset bit resets accel path, output words kept.
// - Temperature path reset bit resets temperature path, output words kept.
// - Motion detector runs only while detect enable bit 7 is one.
// - Compare mode bit 6 one compares with previous sample; zero not used.
// - Host-writable 8-bit motion threshold steers the detector.
// - Any-read-clears option clears status on every read.
// - Motion flag raised only when the three enable bits are all ones.
// - All-paths reset resets every path and clears all output words.
`timescale 1ns/10ps
`include "msr_defs.vh"

module msr_regs #(
    parameter THR_SHIFT = 0
) (
    input  wire        clk_i,
    input  wire        srst_i,
    input  wire [7:0]  reg_addr_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    input  wire [7:0]  reg_wdata_i,
    output reg  [7:0]  reg_rdata_o,
    output reg         reg_rvalid_o,
    input  wire        sample_valid_i,
    input  wire [15:0] accel_x_i,
    input  wire [15:0] accel_y_i,
    input  wire [15:0] accel_z_i,
    input  wire [15:0] temp_i,
    input  wire [15:0] rate_x_i,
    input  wire [15:0] rate_y_i,
    input  wire [15:0] rate_z_i,
    input  wire        queue_overflow_i,
    input  wire        gyro_drive_ready_i,
    input  wire [2:0]  motion_wake_irq_enable_i,
    input  wire        any_read_clears_i,
    output wire [7:0]  status_o,
    output reg         accel_path_rst_o,
    output reg         temp_path_rst_o,
    output reg         gyro_path_rst_o
);

    localparam W     = `MSR_SAMPLE_W;
    localparam WORDS = `MSR_SAMPLE_WORDS;

    reg        motion_wake_status_q;
    reg        queue_overflow_flag_q;
    reg        gyro_drive_ready_flag_q;
    reg        sample_ready_flag_q;
    reg        motion_wake_status_d;
    reg        queue_overflow_flag_d;
    reg        gyro_drive_ready_flag_d;
    reg        sample_ready_flag_d;
    reg [7:0]  motion_threshold_q;
    reg        motion_detect_enable_q;
    reg        motion_compare_mode_q;
    reg        accel_rst_q;
    reg        temp_rst_q;
    reg        all_paths_reset_q;

    wire [WORDS*W-1:0] words;
    wire               motion_event;
    wire               capture;
    wire               status_clear;
    wire               wake_set;
    wire [W-1:0]       accel_x_word;
    wire [W-1:0]       accel_y_word;
    wire [W-1:0]       accel_z_word;
    wire [W-1:0]       temp_word;
    wire [W-1:0]       rate_x_word;
    wire [W-1:0]       rate_y_word;
    wire [W-1:0]       rate_z_word;
    reg  [7:0]         rd_byte;

    // A sample arriving during a path reset belongs to a flushed pipeline, so it is dropped.
    assign capture = sample_valid_i && !accel_rst_q && !temp_rst_q && !all_paths_reset_q;

    // The front end scales rate codes; they are stored unaltered so proportionality is kept.
    msr_sample_bank #(
        .WORDS (WORDS),
        .W     (W)
    ) i_msr_sample_bank (
        .clk_i     (clk_i),
        .srst_i    (srst_i),
        .capture_i (capture),
        .clear_i   (all_paths_reset_q),
        .sample_i  ({rate_z_i, rate_y_i, rate_x_i, temp_i, accel_z_i, accel_y_i, accel_x_i}),
        .words_o   (words)
    );

    msr_motion_det #(
        .AXES      (`MSR_ACCEL_AXES),
        .W         (W),
        .THR_SHIFT (THR_SHIFT)
    ) i_msr_motion_det (
        .clk_i          (clk_i),
        .srst_i         (srst_i),
        .path_rst_i     (accel_rst_q || all_paths_reset_q),
        .enable_i       (motion_detect_enable_q),
        .compare_mode_i (motion_compare_mode_q),
        .threshold_i    (motion_threshold_q),
        .sample_i       (capture),
        .accel_i        ({accel_z_i, accel_y_i, accel_x_i}),
        .event_o        (motion_event)
    );

    assign status_clear = reg_rd_i && (any_read_clears_i || (reg_addr_i == `MSR_OFS_INT_FLAGS));

    assign wake_set = motion_event && (motion_wake_irq_enable_i == `MSR_WAKE_ENABLED);

    // Flags: the clear is applied first and the sets after it, so a set in the same cycle
    // as the clearing read wins and no event is lost.
    always @* begin
        motion_wake_status_d    = motion_wake_status_q;
        queue_overflow_flag_d   = queue_overflow_flag_q;
        gyro_drive_ready_flag_d = gyro_drive_ready_flag_q;
        sample_ready_flag_d     = sample_ready_flag_q;
        if (status_clear) begin
            motion_wake_status_d    = 1'b0;
            queue_overflow_flag_d   = 1'b0;
            gyro_drive_ready_flag_d = 1'b0;
            sample_ready_flag_d     = 1'b0;
        end
        if (wake_set) begin
            motion_wake_status_d = 1'b1;
        end
        if (queue_overflow_i) begin
            queue_overflow_flag_d = 1'b1;
        end
        if (gyro_drive_ready_i) begin
            gyro_drive_ready_flag_d = 1'b1;
        end
        if (capture) begin
            sample_ready_flag_d = 1'b1;
        end
    end

    // The flags sit in flip-flops so that status_o never glitches while the host samples it.
    always @(posedge clk_i) begin
        if (srst_i) begin
            motion_wake_status_q    <= `MSR_RST_FLAG;
            queue_overflow_flag_q   <= `MSR_RST_FLAG;
            gyro_drive_ready_flag_q <= `MSR_RST_FLAG;
            sample_ready_flag_q     <= `MSR_RST_FLAG;
        end else begin
            motion_wake_status_q    <= motion_wake_status_d;
            queue_overflow_flag_q   <= queue_overflow_flag_d;
            gyro_drive_ready_flag_q <= gyro_drive_ready_flag_d;
            sample_ready_flag_q     <= sample_ready_flag_d;
        end
    end

    // Reserved bits 3 and 1 are held at zero.
    assign status_o = {{3{motion_wake_status_q}}, queue_overflow_flag_q, 1'b0,
                       gyro_drive_ready_flag_q, 1'b0, sample_ready_flag_q};

    // Control registers; path reset bits last exactly one cycle.
    always @(posedge clk_i) begin
        if (srst_i) begin
            motion_threshold_q     <= `MSR_RST_MOTION_THR;
            motion_detect_enable_q <= 1'b0;
            motion_compare_mode_q  <= 1'b0;
            accel_rst_q            <= 1'b0;
            temp_rst_q             <= 1'b0;
            all_paths_reset_q      <= 1'b0;
        end else begin
            accel_rst_q       <= 1'b0;
            temp_rst_q        <= 1'b0;
            all_paths_reset_q <= 1'b0;
            if (reg_wr_i) begin
                case (reg_addr_i)
                    `MSR_OFS_MOTION_THR: begin
                        motion_threshold_q <= reg_wdata_i;
                    end
                    `MSR_OFS_PATH_RESET: begin
                        accel_rst_q <= reg_wdata_i[`MSR_BIT_ACCEL_RST];
                        temp_rst_q  <= reg_wdata_i[`MSR_BIT_TEMP_RST];
                    end
                    `MSR_OFS_MOTION_CTRL: begin
                        motion_detect_enable_q <= reg_wdata_i[`MSR_BIT_DETECT_EN];
                        motion_compare_mode_q  <= reg_wdata_i[`MSR_BIT_COMPARE_MODE];
                    end
                    `MSR_OFS_USER_CTRL: begin
                        all_paths_reset_q <= reg_wdata_i[`MSR_BIT_ALL_RST];
                    end
                    default: begin
                        all_paths_reset_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Path reset strobes to the front end follow the control bits one cycle later.
    always @(posedge clk_i) begin
        if (srst_i) begin
            accel_path_rst_o <= 1'b0;
            temp_path_rst_o  <= 1'b0;
            gyro_path_rst_o  <= 1'b0;
        end else begin
            accel_path_rst_o <= accel_rst_q || all_paths_reset_q;
            temp_path_rst_o  <= temp_rst_q || all_paths_reset_q;
            gyro_path_rst_o  <= all_paths_reset_q;
        end
    end

    // Bank order: accel X, Y, Z, temperature, rate X, Y, Z.
    assign accel_x_word = words[0 +: W];
    assign accel_y_word = words[W +: W];
    assign accel_z_word = words[2*W +: W];
    assign temp_word    = words[3*W +: W];
    assign rate_x_word  = words[4*W +: W];
    assign rate_y_word  = words[5*W +: W];
    assign rate_z_word  = words[6*W +: W];

    // The high byte sits at the lower address, so a burst reads each word sign first.
    always @* begin
        rd_byte = `MSR_READ_NONE;
        case (reg_addr_i)
            `MSR_OFS_MOTION_THR: begin
                rd_byte = motion_threshold_q;
            end
            `MSR_OFS_INT_FLAGS: begin
                rd_byte = status_o;
            end
            `MSR_OFS_ACCEL_X_HI: begin
                rd_byte = accel_x_word[15:8];
            end
            `MSR_OFS_ACCEL_X_LO: begin
                rd_byte = accel_x_word[7:0];
            end
            `MSR_OFS_ACCEL_Y_HI: begin
                rd_byte = accel_y_word[15:8];
            end
            `MSR_OFS_ACCEL_Y_LO: begin
                rd_byte = accel_y_word[7:0];
            end
            `MSR_OFS_ACCEL_Z_HI: begin
                rd_byte = accel_z_word[15:8];
            end
            `MSR_OFS_ACCEL_Z_LO: begin
                rd_byte = accel_z_word[7:0];
            end
            `MSR_OFS_TEMP_HI: begin
                rd_byte = temp_word[15:8];
            end
            `MSR_OFS_TEMP_LO: begin
                rd_byte = temp_word[7:0];
            end
            `MSR_OFS_RATE_X_HI: begin
                rd_byte = rate_x_word[15:8];
            end
            `MSR_OFS_RATE_X_LO: begin
                rd_byte = rate_x_word[7:0];
            end
            `MSR_OFS_RATE_Y_HI: begin
                rd_byte = rate_y_word[15:8];
            end
            `MSR_OFS_RATE_Y_LO: begin
                rd_byte = rate_y_word[7:0];
            end
            `MSR_OFS_RATE_Z_HI: begin
                rd_byte = rate_z_word[15:8];
            end
            `MSR_OFS_RATE_Z_LO: begin
                rd_byte = rate_z_word[7:0];
            end
            `MSR_OFS_PATH_RESET: begin
                rd_byte = {6'h00, accel_rst_q, temp_rst_q};
            end
            `MSR_OFS_MOTION_CTRL: begin
                rd_byte = {motion_detect_enable_q, motion_compare_mode_q, 6'h00};
            end
            `MSR_OFS_USER_CTRL: begin
                rd_byte = {7'h00, all_paths_reset_q};
            end
            default: begin
                rd_byte = `MSR_READ_NONE;
            end
        endcase
    end

    // Read data registers the value seen before the clear that the same read triggers.
    always @(posedge clk_i) begin
        if (srst_i) begin
            reg_rdata_o  <= `MSR_READ_NONE;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= rd_byte;
            end
        end
    end

endmodule

// ==== verification/msr_regs_monitor.sv ====
// Checker for msr_regs: read answer, status flags and path reset pulses.
// Assumes it is bound to msr_regs and sees only its ports.
`timescale 1ns/10ps
module msr_regs_monitor (
    input logic       clk_i,
    input logic       srst_i,
    input logic [7:0] reg_addr_i,
    input logic       reg_wr_i,
    input logic       reg_rd_i,
    input logic [7:0] reg_wdata_i,
    input logic [7:0] reg_rdata_o,
    input logic       reg_rvalid_o,
    input logic       sample_valid_i,
    input logic       queue_overflow_i,
    input logic [2:0] motion_wake_irq_enable_i,
    input logic [7:0] status_o,
    input logic       accel_path_rst_o,
    input logic       temp_path_rst_o,
    input logic       gyro_path_rst_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    property p_rd_answer;
        reg_rvalid_o == $past(reg_rd_i);
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer timing");
    property p_flag_read;
        reg_rd_i && reg_addr_i == 8'h3a |=> reg_rdata_o == $past(status_o);
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("status read data");
    property p_ovf_set;
        queue_overflow_i |=> status_o[4];
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");
    property p_ovf_clear;
        reg_rd_i && reg_addr_i == 8'h3a && !queue_overflow_i |=> !status_o[4];
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared");
    // Samples near a write may be dropped by a path reset, so those are left out.
    property p_ready_set;
        sample_valid_i && !$past(reg_wr_i) && !$past(reg_wr_i, 2) |=> status_o[0];
    endproperty
    a_ready_set: assert property (p_ready_set) else $error("sample ready not set");
    property p_reserved;
        status_o[3] == 1'b0 && status_o[1] == 1'b0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved status bit set");
    property p_accel_rst;
        reg_wr_i && reg_addr_i == 8'h68 && reg_wdata_i[1] |-> ##2 accel_path_rst_o ##1 !accel_path_rst_o;
    endproperty
    a_accel_rst: assert property (p_accel_rst) else $error("accel path reset pulse");
    property p_temp_rst;
        reg_wr_i && reg_addr_i == 8'h68 && reg_wdata_i[0] |-> ##2 temp_path_rst_o ##1 !temp_path_rst_o;
    endproperty
    a_temp_rst: assert property (p_temp_rst) else $error("temp path reset pulse");
    property p_all_rst;
        reg_wr_i && reg_addr_i == 8'h6a && reg_wdata_i[0] |-> ##2 gyro_path_rst_o ##1 !gyro_path_rst_o;
    endproperty
    a_all_rst: assert property (p_all_rst) else $error("all paths reset pulse");
    property p_wake_enable;
        $rose(status_o[7]) |-> $past(motion_wake_irq_enable_i) == 3'h7;
    endproperty
    a_wake_enable: assert property (p_wake_enable) else $error("motion flag while disabled");
endmodule

bind msr_regs msr_regs_monitor i_msr_regs_monitor (.clk_i, .srst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .reg_rdata_o, .reg_rvalid_o, .sample_valid_i, .queue_overflow_i, .motion_wake_irq_enable_i, .status_o,
    .accel_path_rst_o, .temp_path_rst_o, .gyro_path_rst_o);

// ==== verification/msr_front_model.sv ====
// Sample front end model: presents one seven-word sample set per command.
// Assumes the bench raises send_i for one cycle with base_i valid.
`timescale 1ns/10ps
module msr_front_model (
    input  logic         clk_i,
    input  logic         send_i,
    input  logic [15:0]  base_i,
    output logic         valid_o,
    output logic [111:0] words_o
);
    logic [15:0] base_q;
    always @(posedge clk_i) begin
        valid_o <= send_i;
        base_q  <= base_i;
    end
    // Outside the valid cycle the lines carry the inverse, so stale data is never mistaken for fresh.
    always_comb begin
        for (int k = 0; k < 7; k++) begin
            words_o[k*16 +: 16] = valid_o ? base_q + 16'(k) * 16'h0203 : ~(base_q + 16'(k) * 16'h0203);
        end
    end
endmodule

// ==== verification/msr_regs_bench.sv ====
// Self-checking bench for msr_regs: register access, sample capture, flags and path resets.
// Assumes the front end model supplies samples and the checker is bound to the design.
`timescale 1ns/10ps
module msr_regs_bench;
    logic         clk_i = 1'b0;
    logic         srst_i = 1'b1;
    logic [7:0]   addr = 8'h00;
    logic         wr = 1'b0;
    logic         rd = 1'b0;
    logic [7:0]   wdata = 8'h00;
    logic [7:0]   rdata;
    logic         rvalid;
    logic         send = 1'b0;
    logic [15:0]  base = 16'h0000;
    logic         valid;
    logic [111:0] w;
    logic         ovf = 1'b0;
    logic         drv = 1'b0;
    logic [2:0]   wen = 3'h0;
    logic         arc = 1'b0;
    int           n_fail = 0;
    int           n_compared = 0;
    always #2 clk_i = ~clk_i;
    msr_front_model i_msr_front_model (.clk_i, .send_i(send), .base_i(base), .valid_o(valid), .words_o(w));
    msr_regs i_msr_regs (.clk_i, .srst_i, .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .sample_valid_i(valid), .accel_x_i(w[15:0]),
        .accel_y_i(w[31:16]), .accel_z_i(w[47:32]), .temp_i(w[63:48]), .rate_x_i(w[79:64]),
        .rate_y_i(w[95:80]), .rate_z_i(w[111:96]), .queue_overflow_i(ovf), .gyro_drive_ready_i(drv),
        .motion_wake_irq_enable_i(wen), .any_read_clears_i(arc), .status_o(), .accel_path_rst_o(),
        .temp_path_rst_o(), .gyro_path_rst_o());
    function automatic logic [7:0] eb(input logic [15:0] b, input int k);
        logic [15:0] v;
        v = b + 16'(k / 2) * 16'h0203;
        return (k % 2 == 0) ? v[15:8] : v[7:0];
    endfunction
    task automatic report_and_stop;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk_i);
        #1;
        wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        #1;
        addr = a;
        rd = 1'b1;
        @(posedge clk_i);
        #1;
        rd = 1'b0;
        n_compared++;
        if (rvalid !== 1'b1 || rdata !== e) begin
            n_fail++;
            $display("CHECK FAILED t=%0t addr %h got %h exp %h", $time, a, rdata, e);
        end
    endtask
    // Waits three edges afterwards so a motion flag has landed before the next read.
    task automatic push(input logic s, input logic [15:0] b, input logic o, input logic d);
        @(posedge clk_i);
        #1;
        send = s;
        base = b;
        ovf = o;
        drv = d;
        @(posedge clk_i);
        #1;
        send = 1'b0;
        ovf = 1'b0;
        drv = 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic rd_set(input logic [15:0] b, input logic z);
        for (int k = 0; k < 14; k++) begin
            rd_chk(8'h3b + 8'(k), z ? 8'h00 : eb(b, k));
        end
    endtask
    initial begin
        #20000;
        n_fail++;
        report_and_stop;
    end
    initial begin
        repeat (2) @(posedge clk_i);
        #1;
        srst_i = 1'b0;
        rd_chk(8'h3a, 8'h00);
        rd_chk(8'h69, 8'h00);
        rd_chk(8'h00, 8'h00);
        push(1'b1, 16'h8a15, 1'b0, 1'b0);
        rd_chk(8'h3a, 8'h01);
        rd_chk(8'h3a, 8'h00);
        wr_reg(8'h3b, 8'h5a);
        rd_set(16'h8a15, 1'b0);
        push(1'b0, 16'h0000, 1'b1, 1'b1);
        rd_chk(8'h3a, 8'h14);
        rd_chk(8'h3a, 8'h00);
        arc = 1'b1;
        push(1'b0, 16'h0000, 1'b1, 1'b0);
        rd_chk(8'h3b, eb(16'h8a15, 0));
        rd_chk(8'h3a, 8'h00);
        arc = 1'b0;
        wr_reg(8'h68, 8'h02);
        rd_chk(8'h68, 8'h00);
        wr_reg(8'h68, 8'h01);
        rd_set(16'h8a15, 1'b0);
        wr_reg(8'h6a, 8'h01);
        rd_set(16'h0000, 1'b1);
        wr_reg(8'h1f, 8'h10);
        rd_chk(8'h1f, 8'h10);
        wr_reg(8'h69, 8'hc0);
        rd_chk(8'h69, 8'hc0);
        wen = 3'h7;
        push(1'b1, 16'h1000, 1'b0, 1'b0);
        rd_chk(8'h3a, 8'h01);
        push(1'b1, 16'h1011, 1'b0, 1'b0);
        rd_chk(8'h3a, 8'he1);
        push(1'b1, 16'h1021, 1'b0, 1'b0);
        rd_chk(8'h3a, 8'h01);
        wen = 3'h0;
        push(1'b1, 16'h2000, 1'b0, 1'b0);
        rd_chk(8'h3a, 8'h01);
        wen = 3'h7;
        wr_reg(8'h69, 8'h40);
        // Two samples with detection off: the second would raise the flag if the enable were ignored.
        push(1'b1, 16'h3000, 1'b0, 1'b0);
        rd_chk(8'h3a, 8'h01);
        push(1'b1, 16'h3100, 1'b0, 1'b0);
        rd_chk(8'h3a, 8'h01);
        report_and_stop;
    end
endmodule
